// ---- hw/core_status_and_interrupt_entry.sv ----
// Purpose: core special registers, flag update and interrupt entry and return
// Assumes: sfr reads answer one clock later; alu ops are one-cycle pulses
// Notes: pending flags for all 13 sources are held here
`timescale 1ns/1ns
`include "core_status_regs.svh"

module core_status_and_interrupt_entry (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire core_status_pkg::sfr_req_t sfr_in,
  output logic [7:0] sfr_rdata_out,
  input wire core_status_pkg::stack_req_t stack_in,
  output logic stack_wr_out,
  output logic [7:0] stack_addr_out,
  input wire core_status_pkg::alu_op_t alu_op_in,
  input wire logic [7:0] alu_src_in,
  input wire logic [7:0] pointer_low_in,
  output logic [15:0] data_pointer_16_out,
  output logic [7:0] bank_base_out,
  input wire core_status_pkg::instr_status_t instr_in,
  input wire logic [12:0] irq_event_in,
  input wire logic [12:0] irq_clear_in,
  output logic [12:0] irq_pending_out,
  output logic call_busy_out,
  output logic isr_enter_out,
  output logic [15:0] isr_vector_out
);

  logic [7:0] stack_top;
  logic [7:0] data_pointer_high;
  logic [7:0] program_status;
  logic [7:0] primary_operand;
  logic [7:0] secondary_operand;
  logic [7:0] irq_enable_reg;
  logic [7:0] irq_enable_ext_reg;
  logic [7:0] irq_priority;
  logic [7:0] irq_priority_ext;
  logic [13:0] pending;
  logic ea_grace;
  logic req_q;
  logic req_hi_q;
  logic [3:0] req_slot_q;
  logic after_return;
  logic in_service_lo;
  logic in_service_hi;
  logic [2:0] call_count;
  core_status_pkg::entry_state_t state;
  core_status_pkg::entry_state_t next_state;

  wire wr_stack = sfr_in.wr && sfr_in.addr == `OFS_STACK_TOP;
  wire wr_dph = sfr_in.wr && sfr_in.addr == `OFS_DATA_POINTER_HIGH;
  wire wr_psw = sfr_in.wr && sfr_in.addr == `OFS_PROGRAM_STATUS;
  wire wr_acc = sfr_in.wr && sfr_in.addr == `OFS_PRIMARY_OPERAND;
  wire wr_b = sfr_in.wr && sfr_in.addr == `OFS_SECONDARY_OPERAND;
  wire wr_ie = sfr_in.wr && sfr_in.addr == `OFS_IRQ_ENABLE;
  wire wr_eie = sfr_in.wr && sfr_in.addr == `OFS_IRQ_ENABLE_EXT;
  wire wr_ip = sfr_in.wr && sfr_in.addr == `OFS_IRQ_PRIORITY;
  wire wr_eip = sfr_in.wr && sfr_in.addr == `OFS_IRQ_PRIORITY_EXT;

  // arithmetic flags
  wire is_add = alu_op_in == core_status_pkg::ALU_ADD || alu_op_in == core_status_pkg::ALU_ADD_WITH_CARRY_IN;
  wire is_sub = alu_op_in == core_status_pkg::ALU_SUBTRACT_WITH_BORROW;
  wire is_mul = alu_op_in == core_status_pkg::ALU_MUL;
  wire is_div = alu_op_in == core_status_pkg::ALU_DIV;
  wire carry_in = (alu_op_in != core_status_pkg::ALU_ADD) && program_status[`PSW_CARRY];
  wire [8:0] sum = {1'b0, primary_operand} + {1'b0, alu_src_in} + {8'h00, carry_in};
  wire [4:0] sum_nib = {1'b0, primary_operand[3:0]} + {1'b0, alu_src_in[3:0]} + {4'h0, carry_in};
  wire [8:0] diff = {1'b0, primary_operand} - {1'b0, alu_src_in} - {8'h00, carry_in};
  wire [4:0] diff_nib = {1'b0, primary_operand[3:0]} - {1'b0, alu_src_in[3:0]} - {4'h0, carry_in};
  wire [15:0] product = primary_operand * secondary_operand;
  wire div_zero = secondary_operand == 8'h00;
  wire [7:0] quotient = div_zero ? primary_operand : primary_operand / secondary_operand;
  wire [7:0] remainder = div_zero ? secondary_operand : primary_operand % secondary_operand;
  wire add_ovf = (primary_operand[7] == alu_src_in[7]) && (sum[7] != primary_operand[7]);
  wire sub_ovf = (primary_operand[7] != alu_src_in[7]) && (diff[7] != primary_operand[7]);
  wire alu_active = is_add || is_sub || is_mul || is_div;
  wire next_carry = is_add ? sum[8] : (is_sub ? diff[8] : 1'b0);
  wire next_half = is_add ? sum_nib[4] : (is_sub ? diff_nib[4] : 1'b0);
  wire next_wrap = (is_add && add_ovf) || (is_sub && sub_ovf)
    || (is_mul && product[15:8] != 8'h00) || (is_div && div_zero);
  wire [7:0] next_acc = is_add ? sum[7:0] : is_sub ? diff[7:0]
    : is_mul ? product[7:0] : quotient;
  wire [7:0] next_b = is_mul ? product[15:8] : remainder;

  wire parity = ^primary_operand;
  wire [7:0] psw_view = {program_status[7:1], parity};

  assign data_pointer_16_out = {data_pointer_high, pointer_low_in};
  assign bank_base_out = {3'h0, program_status[`PSW_BANK_HI:`PSW_BANK_LO], 3'h0};

  // interrupt request decode over 14 vector slots, slot 8 has no source
  wire [13:0] enable_slot = {irq_enable_ext_reg[6:0], irq_enable_reg[6:0]};
  wire [13:0] high_slot = {irq_priority_ext[6:0], irq_priority[6:0]};
  wire ea_open = irq_enable_reg[`IE_GLOBAL] || (ea_grace && !instr_in.next_multi);
  wire [13:0] armed = ea_open ? (pending & enable_slot) : 14'h0000;
  wire [13:0] armed_hi = armed & high_slot;
  wire [13:0] armed_lo = armed & ~high_slot;
  wire take_hi = armed_hi != 14'h0000 && !in_service_hi;
  wire take_lo = armed_lo != 14'h0000 && !in_service_hi && !in_service_lo;
  wire [13:0] pick_set = take_hi ? armed_hi : armed_lo;
  logic [3:0] pick_slot;

  always_comb begin
    pick_slot = 4'h0;
    for (int i = `IRQ_SLOTS - 1; i >= 0; i--) begin
      if (pick_set[i]) begin
        pick_slot = i[3:0];
      end
    end
  end

  wire call_start = state == core_status_pkg::ENTRY_IDLE && req_q && instr_in.done
    && !after_return;
  wire call_end = state == core_status_pkg::ENTRY_CALL && call_count == `CALL_CYCLES;

  genvar g;
  generate
    for (g = 0; g < `IRQ_SLOTS; g++) begin : g_pending
      if (g == `IRQ_RESERVED_SLOT) begin : g_none
        assign pending[g] = 1'b0;
      end else begin : g_flag
        localparam int SRC = g < `IRQ_RESERVED_SLOT ? g : g - 1;
        localparam logic [13:0] HW_MASK = `IRQ_HW_CLEAR_MASK;
        localparam logic HW_CLR = HW_MASK[g];
        logic flag;
        wire entry_clr = HW_CLR && call_end && req_slot_q == g;
        always_ff @(posedge ref_clk_in) begin
          if (srst_in) begin
            flag <= 1'b0;
          end else if (irq_event_in[SRC]) begin
            flag <= 1'b1;
          end else if (irq_clear_in[SRC] || entry_clr) begin
            flag <= 1'b0;
          end
        end
        assign pending[g] = flag;
        assign irq_pending_out[SRC] = flag;
      end
    end
  endgenerate

  always_comb begin
    unique case (state)
      core_status_pkg::ENTRY_IDLE: next_state = call_start ? core_status_pkg::ENTRY_CALL : state;
      core_status_pkg::ENTRY_CALL: next_state = call_end ? core_status_pkg::ENTRY_IDLE : state;
    endcase
  end

  // entry sequencer: one clock to sample, four to make the call
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state <= core_status_pkg::ENTRY_IDLE;
      req_q <= 1'b0;
      req_hi_q <= 1'b0;
      req_slot_q <= 4'h0;
      call_count <= 3'h0;
      isr_enter_out <= 1'b0;
      isr_vector_out <= 16'h0000;
    end else begin
      state <= next_state;
      isr_enter_out <= call_end;
      // the call spends its request; a stale one would re-enter at call end
      if (state == core_status_pkg::ENTRY_IDLE && !call_start) begin
        req_q <= take_hi || take_lo;
        req_hi_q <= take_hi;
        req_slot_q <= pick_slot;
      end else begin
        req_q <= 1'b0;
      end
      call_count <= state == core_status_pkg::ENTRY_CALL ? call_count + 3'h1 : 3'h1;
      if (call_start) begin
        isr_vector_out <= `VECTOR_BASE + {9'h000, req_slot_q, 3'h0};
      end
    end
  end

  assign call_busy_out = state == core_status_pkg::ENTRY_CALL;

  // nesting: a return closes the highest open level and holds off one instruction
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      in_service_lo <= 1'b0;
      in_service_hi <= 1'b0;
      after_return <= 1'b0;
      ea_grace <= 1'b0;
    end else begin
      if (call_end && req_hi_q) begin
        in_service_hi <= 1'b1;
      end else if (call_end) begin
        in_service_lo <= 1'b1;
      end else if (instr_in.interrupt_return && in_service_hi) begin
        in_service_hi <= 1'b0;
      end else if (instr_in.interrupt_return) begin
        in_service_lo <= 1'b0;
      end
      if (instr_in.interrupt_return) begin
        after_return <= 1'b1;
      end else if (instr_in.done) begin
        after_return <= 1'b0;
      end
      // a request posted with the clear lands only if a one-cycle instruction follows
      if (wr_ie && irq_enable_reg[`IE_GLOBAL] && !sfr_in.wdata[`IE_GLOBAL]) begin
        ea_grace <= 1'b1;
      end else if (instr_in.done) begin
        ea_grace <= 1'b0;
      end
    end
  end

  // special registers; a direct write wins over the implied update
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      stack_top <= `RST_STACK_TOP;
      data_pointer_high <= `RST_BYTE;
      program_status <= `RST_BYTE;
      primary_operand <= `RST_BYTE;
      secondary_operand <= `RST_BYTE;
      irq_enable_reg <= `RST_BYTE;
      irq_enable_ext_reg <= `RST_BYTE;
      irq_priority <= `RST_BYTE;
      irq_priority_ext <= `RST_BYTE;
      stack_wr_out <= 1'b0;
      stack_addr_out <= `RST_BYTE;
    end else begin
      stack_wr_out <= stack_in.push && !wr_stack;
      if (wr_stack) begin
        stack_top <= sfr_in.wdata;
      end else if (stack_in.push) begin
        stack_top <= stack_top + 8'h01;
        stack_addr_out <= stack_top + 8'h01;
      end else if (stack_in.pop) begin
        stack_top <= stack_top - 8'h01;
        stack_addr_out <= stack_top;
      end
      if (wr_dph) begin
        data_pointer_high <= sfr_in.wdata;
      end
      if (wr_psw) begin
        program_status <= {sfr_in.wdata[7:1], 1'b0};
      end else if (alu_active) begin
        program_status[`PSW_CARRY] <= next_carry;
        program_status[`PSW_HALF_CARRY] <= next_half;
        program_status[`PSW_WRAP] <= next_wrap;
      end
      if (wr_acc) begin
        primary_operand <= sfr_in.wdata;
      end else if (alu_active) begin
        primary_operand <= next_acc;
      end
      if (wr_b) begin
        secondary_operand <= sfr_in.wdata;
      end else if (is_mul || is_div) begin
        secondary_operand <= next_b;
      end
      if (wr_ie) begin
        irq_enable_reg <= sfr_in.wdata;
      end
      if (wr_eie) begin
        irq_enable_ext_reg <= sfr_in.wdata;
      end
      if (wr_ip) begin
        irq_priority <= sfr_in.wdata;
      end
      if (wr_eip) begin
        irq_priority_ext <= sfr_in.wdata;
      end
    end
  end

  logic [7:0] read_mux;
  always_comb begin
    unique case (sfr_in.addr)
      `OFS_STACK_TOP: read_mux = stack_top;
      `OFS_DATA_POINTER_HIGH: read_mux = data_pointer_high;
      `OFS_PROGRAM_STATUS: read_mux = psw_view;
      `OFS_PRIMARY_OPERAND: read_mux = primary_operand;
      `OFS_SECONDARY_OPERAND: read_mux = secondary_operand;
      `OFS_IRQ_ENABLE: read_mux = irq_enable_reg;
      `OFS_IRQ_ENABLE_EXT: read_mux = irq_enable_ext_reg;
      `OFS_IRQ_PRIORITY: read_mux = irq_priority;
      `OFS_IRQ_PRIORITY_EXT: read_mux = irq_priority_ext;
      default: read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      sfr_rdata_out <= 8'h00;
    end else if (sfr_in.rd) begin
      sfr_rdata_out <= read_mux;
    end
  end

endmodule

// ---- hw/core_status_regs.svh ----
// Purpose: offsets, field positions, reset values and counts for the core status block
// Assumes: byte-wide special register port, 8-bit addresses
// Notes: definitions only
`ifndef CORE_STATUS_REGS_SVH
`define CORE_STATUS_REGS_SVH

`define OFS_STACK_TOP 8'h81
`define OFS_DATA_POINTER_HIGH 8'h83
`define OFS_IRQ_ENABLE 8'hA8
`define OFS_IRQ_PRIORITY 8'hB8
`define OFS_PROGRAM_STATUS 8'hD0
`define OFS_PRIMARY_OPERAND 8'hE0
`define OFS_IRQ_ENABLE_EXT 8'hE6
`define OFS_SECONDARY_OPERAND 8'hF0
`define OFS_IRQ_PRIORITY_EXT 8'hF6

`define RST_STACK_TOP 8'h07
`define RST_BYTE 8'h00

`define PSW_CARRY 7
`define PSW_HALF_CARRY 6
`define PSW_USER0 5
`define PSW_BANK_HI 4
`define PSW_BANK_LO 3
`define PSW_WRAP 2
`define PSW_USER1 1
`define PSW_PARITY 0
`define IE_GLOBAL 7

`define IRQ_SOURCES 13
`define IRQ_SLOTS 14
`define IRQ_RESERVED_SLOT 8
`define IRQ_HW_CLEAR_MASK 14'h000F
`define VECTOR_BASE 16'h0003
`define VECTOR_STRIDE_SHIFT 3
`define CALL_CYCLES 3'h4

`endif

// ---- hw/core_status_pkg.sv ----
// Purpose: types shared by the core status block and its bench
// Assumes: constants live in core_status_regs.svh
// Notes: none
package core_status_pkg;

  typedef enum logic [2:0] {
    ALU_NONE = 3'h0,
    ALU_ADD = 3'h1,
    ALU_ADD_WITH_CARRY_IN = 3'h2,
    ALU_SUBTRACT_WITH_BORROW = 3'h3,
    ALU_MUL = 3'h4,
    ALU_DIV = 3'h5
  } alu_op_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic push;
    logic pop;
  } stack_req_t;

  typedef struct packed {
    logic done;
    logic next_multi;
    logic interrupt_return;
  } instr_status_t;

  typedef enum logic [1:0] {
    ENTRY_IDLE = 2'b00,
    ENTRY_CALL = 2'b01
  } entry_state_t;

endpackage

// ---- verif/irq_source_model.sv ----
// Purpose: stand-in for peripherals and pins that set pending flags
// Assumes: caller sits at a falling edge
// Notes: event lines idle low
`timescale 1ns/1ns
module irq_source_model (
  input wire logic ref_clk_in,
  output logic [12:0] irq_event_out
);
  initial irq_event_out = 13'h0000;
  // one-clock condition pulse, raised whatever the enables
  task automatic raise(input int idx);
    irq_event_out[idx] = 1'b1;
    @(negedge ref_clk_in);
    irq_event_out[idx] = 1'b0;
  endtask
endmodule

// ---- verif/core_status_checker.sv ----
// Purpose: port-level checks of the core status block
// Assumes: no stack top write lands in a push cycle
// Notes: bound from the bench top
`timescale 1ns/1ns
`include "core_status_regs.svh"
module core_status_checker (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire core_status_pkg::sfr_req_t sfr_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire core_status_pkg::stack_req_t stack_in,
  input wire logic stack_wr_out,
  input wire logic [7:0] stack_addr_out,
  input wire core_status_pkg::alu_op_t alu_op_in,
  input wire logic [7:0] alu_src_in,
  input wire logic [7:0] pointer_low_in,
  input wire logic [15:0] data_pointer_16_out,
  input wire logic [7:0] bank_base_out,
  input wire core_status_pkg::instr_status_t instr_in,
  input wire logic [12:0] irq_event_in,
  input wire logic [12:0] irq_clear_in,
  input wire logic [12:0] irq_pending_out,
  input wire logic call_busy_out,
  input wire logic isr_enter_out,
  input wire logic [15:0] isr_vector_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  wire psh = stack_in.push && !(sfr_in.wr && sfr_in.addr == `OFS_STACK_TOP);
  property p_push_wr; psh |=> stack_wr_out; endproperty
  a_push_wr: assert property (p_push_wr) else $error("push gave no write");
  property p_push_inc;
    psh ##1 psh |=> stack_addr_out == $past(stack_addr_out) + 8'h01;
  endproperty
  a_push_inc: assert property (p_push_inc) else $error("push not pre-incremented");
  property p_dp; data_pointer_16_out[7:0] == pointer_low_in; endproperty
  a_dp: assert property (p_dp) else $error("pointer low byte lost");
  property p_bank; bank_base_out[2:0] == 3'h0 && bank_base_out[7:5] == 3'h0; endproperty
  a_bank: assert property (p_bank) else $error("bank base off grid");
  property p_busy;
    $rose(call_busy_out) |-> call_busy_out [*4] ##1 (!call_busy_out && isr_enter_out);
  endproperty
  a_busy: assert property (p_busy) else $error("call length wrong");
  property p_start; $rose(call_busy_out) |-> $past(instr_in.done); endproperty
  a_start: assert property (p_start) else $error("call before done");
  property p_pend;
    irq_event_in != 13'h0000 && !call_busy_out
      |=> (irq_pending_out & $past(irq_event_in)) == $past(irq_event_in);
  endproperty
  a_pend: assert property (p_pend) else $error("event not flagged");
  property p_idle; irq_pending_out == 13'h0000 |-> ##2 !$rose(call_busy_out); endproperty
  a_idle: assert property (p_idle) else $error("call with nothing pending");
  property p_clr;
    isr_enter_out && isr_vector_out == `VECTOR_BASE |-> !irq_pending_out[0];
  endproperty
  a_clr: assert property (p_clr) else $error("flag 0 kept on entry");
  property p_keep;
    isr_enter_out && isr_vector_out == 16'h0023 && !$past(irq_clear_in[4])
      |-> irq_pending_out[4];
  endproperty
  a_keep: assert property (p_keep) else $error("flag 4 lost on entry");
  c_call: cover property ($rose(call_busy_out));
  c_four: cover property (isr_enter_out && isr_vector_out == 16'h0023);
  c_push: cover property (stack_wr_out);
endmodule

// ---- verif/core_status_and_interrupt_entry_test.sv ----
// Purpose: directed bench for the core status block
// Assumes: every instruction completes in one clock
// Notes: pointer low byte and done are held constant; next_multi is raised only in t_grace
`timescale 1ns/1ns
`include "core_status_regs.svh"
module core_status_and_interrupt_entry_test;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  core_status_pkg::sfr_req_t sfr = '0;
  core_status_pkg::stack_req_t stk = '0;
  core_status_pkg::alu_op_t op = core_status_pkg::ALU_NONE;
  core_status_pkg::instr_status_t ins = 3'h4;
  logic [7:0] src = 8'h00;
  logic [12:0] clr = 13'h0000;
  wire [12:0] ev, pend;
  wire [7:0] rdata, saddr, bank;
  wire swr, busy, enter;
  wire [15:0] data_pointer_16, vec;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  core_status_and_interrupt_entry u_core_status_and_interrupt_entry (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .sfr_in(sfr), .sfr_rdata_out(rdata),
    .stack_in(stk), .stack_wr_out(swr), .stack_addr_out(saddr), .alu_op_in(op),
    .alu_src_in(src), .pointer_low_in(8'h5C), .data_pointer_16_out(data_pointer_16),
    .bank_base_out(bank), .instr_in(ins), .irq_event_in(ev), .irq_clear_in(clr),
    .irq_pending_out(pend), .call_busy_out(busy), .isr_enter_out(enter),
    .isr_vector_out(vec));
  irq_source_model u_irq_source_model (.ref_clk_in(ref_clk_in), .irq_event_out(ev));
  initial forever #4 ref_clk_in = ~ref_clk_in;
  // a hang is cut off far past the couple of hundred clocks the scenarios need
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic summarize();
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // each access waits a falling edge first so strobes never toggle twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    sfr = '{1'b1, 1'b0, a, d};
    @(negedge ref_clk_in);
    sfr = '0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk_in);
    sfr = '{1'b0, 1'b1, a, 8'h00};
    @(negedge ref_clk_in);
    sfr = '0;
    chk({8'h00, rdata}, {8'h00, e});
  endtask
  task automatic interrupt_return();
    @(negedge ref_clk_in);
    ins.interrupt_return = 1'b1;
    @(negedge ref_clk_in);
    ins.interrupt_return = 1'b0;
  endtask
  task automatic wait_enter(input logic [15:0] v);
    int n;
    n = 0;
    while (enter !== 1'b1 && n < 40) begin
      @(negedge ref_clk_in);
      n++;
    end
    chk({15'h0000, enter}, 16'h0001);
    chk(vec, v);
  endtask
  task automatic t_reset();
    rc(`OFS_STACK_TOP, `RST_STACK_TOP);
    rc(`OFS_DATA_POINTER_HIGH, 8'h00);
    rc(`OFS_PROGRAM_STATUS, 8'h00);
    rc(`OFS_PRIMARY_OPERAND, 8'h00);
    rc(`OFS_SECONDARY_OPERAND, 8'h00);
    rc(8'h80, 8'h00);
  endtask
  task automatic t_regs();
    wr(`OFS_DATA_POINTER_HIGH, 8'hA5);
    chk(data_pointer_16, 16'hA55C);
    for (int b = 0; b < 4; b++) begin
      wr(`OFS_PROGRAM_STATUS, 8'(b << 3) | 8'h23);
      chk({8'h00, bank}, 16'(b * 8));
      rc(`OFS_PROGRAM_STATUS, 8'(b << 3) | 8'h22);
    end
    wr(`OFS_PROGRAM_STATUS, 8'h00);
  endtask
  task automatic t_stack();
    @(negedge ref_clk_in);
    stk.push = 1'b1;
    @(negedge ref_clk_in);
    chk({7'h00, swr, saddr}, 16'h0108);
    @(negedge ref_clk_in);
    stk.push = 1'b0;
    chk({7'h00, swr, saddr}, 16'h0109);
    rc(`OFS_STACK_TOP, 8'h09);
  endtask
  task automatic t_alu();
    core_status_pkg::alu_op_t ops [7] = '{core_status_pkg::ALU_ADD,
      core_status_pkg::ALU_ADD_WITH_CARRY_IN, core_status_pkg::ALU_SUBTRACT_WITH_BORROW, core_status_pkg::ALU_ADD,
      core_status_pkg::ALU_DIV, core_status_pkg::ALU_DIV, core_status_pkg::ALU_MUL};
    logic [7:0] a [7] = '{8'hFF, 8'h10, 8'h00, 8'h7F, 8'h05, 8'h07, 8'h10};
    logic [7:0] b [7] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h02, 8'h10};
    logic [7:0] ea [7] = '{8'h00, 8'h12, 8'hFF, 8'h80, 8'h05, 8'h03, 8'h00};
    logic [7:0] ep [7] = '{8'hC0, 8'h00, 8'hC0, 8'h45, 8'h04, 8'h00, 8'h04};
    for (int i = 0; i < 7; i++) begin
      wr(`OFS_PRIMARY_OPERAND, a[i]);
      wr(`OFS_SECONDARY_OPERAND, b[i]);
      @(negedge ref_clk_in);
      op = ops[i];
      src = b[i];
      @(negedge ref_clk_in);
      op = core_status_pkg::ALU_NONE;
      rc(`OFS_PRIMARY_OPERAND, ea[i]);
      rc(`OFS_PROGRAM_STATUS, ep[i]);
    end
    rc(`OFS_SECONDARY_OPERAND, 8'h01);
  endtask
  task automatic t_mask();
    wr(`OFS_IRQ_ENABLE, 8'h01);
    u_irq_source_model.raise(0);
    clr = 13'h0004;
    u_irq_source_model.raise(2);
    clr = 13'h0000;
    repeat (10) @(negedge ref_clk_in);
    chk({3'h0, pend}, 16'h0005);
    clr = 13'h0004;
    wr(`OFS_IRQ_ENABLE, 8'h80);
    clr = 13'h0000;
    repeat (10) @(negedge ref_clk_in);
    chk({3'h0, pend}, 16'h0001);
    wr(`OFS_IRQ_ENABLE, 8'h81);
    wait_enter(`VECTOR_BASE);
    chk({3'h0, pend}, 16'h0000);
    interrupt_return();
  endtask
  task automatic t_reenter();
    wr(`OFS_IRQ_ENABLE, 8'h90);
    u_irq_source_model.raise(4);
    wait_enter(16'h0023);
    chk({3'h0, pend}, 16'h0010);
    interrupt_return();
    wait_enter(16'h0023);
    clr = 13'h0010;
    interrupt_return();
    clr = 13'h0000;
    repeat (12) @(negedge ref_clk_in);
    chk({2'h0, enter, pend}, 16'h0000);
  endtask
  // global enable cleared in the cycle a flag is posted
  task automatic t_grace();
    wr(`OFS_IRQ_ENABLE, 8'h82);
    ins.next_multi = 1'b1;
    @(negedge ref_clk_in);
    sfr = '{1'b1, 1'b0, `OFS_IRQ_ENABLE, 8'h02};
    u_irq_source_model.raise(1);
    sfr = '0;
    repeat (10) @(negedge ref_clk_in);
    chk({3'h0, pend}, 16'h0002);
    clr = 13'h0002;
    wr(`OFS_IRQ_ENABLE, 8'h82);
    clr = 13'h0000;
    ins.next_multi = 1'b0;
    @(negedge ref_clk_in);
    sfr = '{1'b1, 1'b0, `OFS_IRQ_ENABLE, 8'h02};
    u_irq_source_model.raise(1);
    sfr = '0;
    wait_enter(16'h000B);
    rc(`OFS_IRQ_ENABLE, 8'h02);
    interrupt_return();
  endtask
  initial begin
    repeat (6) @(negedge ref_clk_in);
    srst_in = 1'b0;
    t_reset();
    t_regs();
    t_stack();
    t_alu();
    t_mask();
    t_reenter();
    t_grace();
    summarize();
  end
endmodule
bind core_status_and_interrupt_entry core_status_checker u_core_status_checker (.*);
